// ### testbench/fsdp_mem_model.sv
// Purpose: program and data memory beside the pipeline
// Assumes: zero-wait answers unless slow is high
// Notes:   unselected ports show inverted patterns, not stale data
`timescale 1ns/100ps
module fsdp_mem_model
(
   input  wire logic        slow,
   input  wire logic [15:0] progAddr,
   input  wire logic        progRead,
   output logic      [15:0] progData,
   output logic             progReady,
   input  wire logic [15:0] dataRdAddr,
   input  wire logic        dataRdEn,
   output logic      [15:0] dataRdata,
   output logic             dataRdReady
);
   logic [15:0] word;
   // ----------------------------------------
   // program image
   // ----------------------------------------
   always_comb
   begin
      case (progAddr)
         16'h0000, 16'h0002: word = 16'hC800;
         16'h0001: word = 16'h000C;
         16'h0003: word = 16'h2010;
         16'h0004: word = 16'h0010;
         16'h0010: word = 16'hC002;
         16'h0011: word = 16'h2040;
         16'h0012, 16'h0013: word = 16'h0030;
         default: word = 16'h0000;
      endcase
   end
   // waits hit both ports at once, worst case for the hold logic
   assign progReady   = !slow;
   assign dataRdReady = !slow;
   assign progData    = progRead ? word : ~progAddr;
   assign dataRdata   = dataRdEn ? dataRdAddr + 16'h0100 : ~dataRdAddr;
endmodule

// ### testbench/fsdp_pipeline_monitor.sv
// Purpose: port-level checks of the pipeline control
// Assumes: stall is any wait on the three memory ports
// Notes:   one clock domain, defaults declared once
`timescale 1ns/100ps
module fsdp_pipeline_monitor
   import fsdp_pkg::*;
(
   input wire logic        clock,
   input wire logic        rstn,
   input wire logic [15:0] progAddr,
   input wire logic        progRead,
   input wire logic        progReady,
   input wire logic        dataRdEn,
   input wire logic        dataRdReady,
   input wire logic        dataWrEn,
   input wire logic        dataWrReady,
   input wire logic        condTrue,
   input wire logic [15:0] stackTop,
   input wire logic        execValid,
   input wire logic [15:0] execWord,
   input wire logic [15:0] execImm,
   input wire logic [15:0] execPc,
   input wire logic        mpyOperandLoad,
   input wire logic        retPop,
   input wire logic        pipeFlush
);
   logic       stall;
   logic       taken;
   logic [2:0] flow;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   assign flow  = execWord[6:4];
   assign stall = (progRead && !progReady) || (dataRdEn && !dataRdReady) || (dataWrEn && !dataWrReady);
   assign taken = execValid && (flow inside {3'h1, 3'h2, 3'h3} || (flow == 3'h4 && condTrue));
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   a_pc_advance: assert property (progRead && !stall && !taken |=> progAddr == $past(progAddr) + 16'h0001)
      else $error("pc did not step");
   a_branch_target: assert property (taken && !stall && flow != 3'h3 |=> pipeFlush && progAddr == $past(execImm))
      else $error("branch target not loaded");
   a_flush_gap: assert property (taken && !stall |=> !execValid [*3])
      else $error("flush too short");
   a_ret_pop: assert property (taken && !stall && flow == 3'h3 |=> retPop && progAddr == $past(stackTop))
      else $error("return target wrong");
   a_stall_hold: assert property (stall |=> $stable(execPc) && $stable(progAddr))
      else $error("pipeline moved in stall");
   a_read_needed: assert property (dataRdEn && !stall && !taken |=> execValid && execWord[15:14] == 2'h3 && !execWord[3])
      else $error("read without operand");
   a_write_exec: assert property (dataWrEn |-> execValid && execWord[1])
      else $error("write outside execute");
   a_mpy_load: assert property (mpyOperandLoad |-> execValid && execWord[2])
      else $error("mpy load outside execute");
   a_second_dummy: assert property (execValid && execWord[13] && !stall && !taken |=> !execValid)
      else $error("second word executed");
   a_cond_false: assert property (execValid && flow == 3'h4 && !condTrue && !stall |=> !pipeFlush)
      else $error("untaken branch flushed");
endmodule
bind fsdp_pipeline_ctrl fsdp_pipeline_monitor i_fsdp_pipeline_monitor (
   .clock(clock), .rstn(rstn), .progAddr(progAddr), .progRead(progRead), .progReady(progReady),
   .dataRdEn(dataRdEn), .dataRdReady(dataRdReady), .dataWrEn(dataWrEn), .dataWrReady(dataWrReady),
   .condTrue(condTrue), .stackTop(stackTop), .execValid(execValid), .execWord(execWord),
   .execImm(execImm), .execPc(execPc), .mpyOperandLoad(mpyOperandLoad), .retPop(retPop),
   .pipeFlush(pipeFlush));

// ### testbench/tb_four_stage_dsp_pipeline.sv
// Purpose: self-checking bench of the pipeline control
// Assumes: program image held in the memory model
// Notes:   rows list the instructions seen in execute, in order
`timescale 1ns/100ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin bad_count++; $display("ERROR %s exp %h got %h", n, e, s); end end
module tb_four_stage_dsp_pipeline;
   import fsdp_pkg::*;
   logic        clock = 0;
   logic        rstn = 0;
   logic        slow = 0;
   logic        condTrue = 0;
   logic [15:0] storeData = 16'hA5A5;
   logic [15:0] stackTop = 16'h0020;
   logic [15:0] progAddr, progData, dataRdAddr, dataRdata, dataWrAddr, dataWrData;
   logic [15:0] execWord, execOperand, execImm, execPc, callReturnAddr, pc0, pa0;
   logic        progRead, progReady, dataRdEn, dataRdReady, dataWrEn;
   logic        execValid, mpyOperandLoad, callPush, retPop, pipeFlush;
   logic [47:0] rows [8] = '{48'h0000_C800_0100, 48'h0001_000C_0000, 48'h0002_C800_0101,
      48'h0003_2010_0000, 48'h0010_C002_0102, 48'h0011_2040_0000, 48'h0013_0030_0000, 48'h0020_0000_0000};
   int          bad_count = 0;
   int          comparisons = 0;
   int          cyc = 0;
   int          n;
   int          tc;
   int          t [8];
   always #2 clock = ~clock;
   fsdp_pipeline_ctrl i_fsdp_pipeline_ctrl (.clock(clock), .rstn(rstn), .progAddr(progAddr), .progRead(progRead),
      .progData(progData), .progReady(progReady), .dataRdAddr(dataRdAddr), .dataRdEn(dataRdEn),
      .dataRdata(dataRdata), .dataRdReady(dataRdReady), .dataWrAddr(dataWrAddr), .dataWrEn(dataWrEn),
      .dataWrData(dataWrData), .dataWrReady(!slow), .storeData(storeData), .condTrue(condTrue),
      .stackTop(stackTop), .execValid(execValid), .execWord(execWord), .execOperand(execOperand),
      .execImm(execImm), .execPc(execPc), .mpyOperandLoad(mpyOperandLoad), .callPush(callPush),
      .callReturnAddr(callReturnAddr), .retPop(retPop), .pipeFlush(pipeFlush));
   fsdp_mem_model i_fsdp_mem_model (.slow(slow), .progAddr(progAddr), .progRead(progRead),
      .progData(progData), .progReady(progReady), .dataRdAddr(dataRdAddr), .dataRdEn(dataRdEn),
      .dataRdata(dataRdata), .dataRdReady(dataRdReady));
   // ----------------------------------------
   // verdict and hang guard
   // ----------------------------------------
   task automatic end_of_test();
      if (bad_count == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   always @(posedge clock)
   begin
      cyc <= cyc + 1;
      if (cyc == 2000)
      begin
         bad_count++;
         end_of_test();
      end
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      repeat (2) @(negedge clock);
      `CHK("progRead", 1'b0, progRead)
      `CHK("progAddr", 16'h0000, progAddr)
      repeat (2) @(posedge clock);
      rstn <= 1;
      for (int i = 0; i < 8; i++)
      begin
         n = 0;
         @(negedge clock);
         while (execValid !== 1'b1 && n < 20)
         begin
            @(negedge clock);
            n++;
         end
         t[i] = cyc;
         `CHK("execPc", rows[i][47:32], execPc)
         `CHK("execWord", rows[i][31:16], execWord)
         `CHK("execOperand", rows[i][15:0], execOperand)
         `CHK("mpyLoad", rows[i][18], mpyOperandLoad)
         `CHK("wrEn", rows[i][17], dataWrEn)
         if (rows[i][17])
            `CHK("wrData", storeData, dataWrData)
      end
      `CHK("gap01", 1, t[1] - t[0])
      `CHK("gap23", 1, t[3] - t[2])
      `CHK("branch", 4, t[4] - t[3])
      `CHK("untaken", 2, t[6] - t[5])
      `CHK("return", 4, t[7] - t[6])
      // wait states on all three ports at once
      @(posedge clock);
      slow <= 1;
      @(negedge clock);
      pc0 = execPc;
      pa0 = progAddr;
      repeat (3) @(negedge clock);
      `CHK("stallPc", pc0, execPc)
      `CHK("stallFetch", pa0, progAddr)
      @(posedge clock);
      slow <= 0;
      repeat (3) @(negedge clock);
      `CHK("resume", pa0 + 16'h0002, progAddr)
      // mid-run reset, then the conditional branch taken
      @(posedge clock);
      rstn     <= 0;
      condTrue <= 1;
      repeat (4) @(posedge clock);
      rstn <= 1;
      @(negedge clock);
      `CHK("rstRead", 1'b0, progRead)
      @(negedge clock);
      `CHK("rstFetch", 1'b1, progRead)
      `CHK("rstAddr", 16'h0000, progAddr)
      n = 0;
      while (!(execValid === 1'b1 && execPc === 16'h0011) && n < 40)
      begin
         @(negedge clock);
         n++;
      end
      tc = cyc;
      `CHK("condPc", 16'h0011, execPc)
      @(negedge clock);
      `CHK("condFlush", 1'b1, pipeFlush)
      `CHK("condTarget", 16'h0030, progAddr)
      n = 0;
      while (execValid !== 1'b1 && n < 20)
      begin
         @(negedge clock);
         n++;
      end
      `CHK("condCost", 4, cyc - tc)
      `CHK("condDest", 16'h0030, execPc)
      end_of_test();
   end
endmodule

// ### verilog/fsdp_aux_unit.sv
// Purpose: aux register file, pointer and arithmetic update
// Assumes: update strobe comes from the decode phase only
// Notes:   curAr shows the pointed register before this cycle's update

`timescale 1ns/100ps

module fsdp_aux_unit
   import fsdp_pkg::*;
#(
   parameter int NUM_AR = FSDP_NAR,
   parameter int AW     = FSDP_AW
)
(
   input  wire logic                 clock,
   input  wire logic                 rstn,
   input  wire logic                 update,
   input  wire logic [1:0]           arMod,
   input  wire logic                 newArpValid,
   input  wire logic [FSDP_ARPW-1:0] newArp,
   output logic      [AW-1:0]        curAr,
   output logic      [FSDP_ARPW-1:0] curArp
);

   typedef struct packed
   {
      logic [NUM_AR-1:0][AW-1:0] ar;
      logic [FSDP_ARPW-1:0]      aux_reg_pointer;
   } fsdp_aux_t;

   fsdp_aux_t aux_reg;
   fsdp_aux_t aux_next;

   // ----------------------------------------------------------------
   // update
   // ----------------------------------------------------------------
   always_comb
   begin
      aux_next = aux_reg;
      if (update)
      begin
         case (arMod)
            FSDP_ARMOD_INC:  aux_next.ar[aux_reg.aux_reg_pointer] = aux_reg.ar[aux_reg.aux_reg_pointer] + AW'(1);
            FSDP_ARMOD_DEC:  aux_next.ar[aux_reg.aux_reg_pointer] = aux_reg.ar[aux_reg.aux_reg_pointer] - AW'(1);
            default:         aux_next.ar[aux_reg.aux_reg_pointer] = aux_reg.ar[aux_reg.aux_reg_pointer];
         endcase
         if (newArpValid)
         begin
            aux_next.aux_reg_pointer = newArp;
         end
      end
   end

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         aux_reg     <= '0;
         aux_reg.aux_reg_pointer <= FSDP_ARP_RESET;
      end
      else
      begin
         aux_reg <= aux_next;
      end
   end

   // pre-update value, so the read phase sees the old pointer
   assign curAr  = aux_reg.ar[aux_reg.aux_reg_pointer];
   assign curArp = aux_reg.aux_reg_pointer;

endmodule

// ### verilog/fsdp_pipeline_ctrl.sv
// Purpose: fetch, decode, read, execute control of the dsp core pipeline
// Assumes: memories answer in the cycle a request stands, ready low adds waits
// Notes:   no hazard protection; software orders code around conflicts
//
// Contract
// - fetch reads word and advances pc
// - decode makes address and aux update
// - read phase reads memory only when needed
// - indirect read uses pointer before decode update
// - execute operates and writes earlier result
// - four phases overlap, one completion per cycle
// - no priority or interlock on conflicts
// - pipeline effects left visible to software
// - second word becomes a decode dummy
// - dummy slot flows on as no-op
// - mapped store: no address, no aux update
// - no operand: read port stays free
// - new pointer applied in decode phase
// - multiplier operand loaded in execute phase
// - branch, call, return cost four cycles
// - taken conditional branch costs four cycles
// - taken branch loads target, dummies decode
// - untaken branch continues as two-word

`timescale 1ns/100ps

module fsdp_pipeline_ctrl
   import fsdp_pkg::*;
#(
   parameter int AW = FSDP_AW,
   parameter int DW = FSDP_DW
)
(
   // ----------------------------------------------------------------
   // clock and reset
   // ----------------------------------------------------------------
   input  wire logic          clock,
   input  wire logic          rstn,
   // ----------------------------------------------------------------
   // program memory port
   // ----------------------------------------------------------------
   output logic      [AW-1:0] progAddr,
   output logic               progRead,
   input  wire logic [DW-1:0] progData,
   input  wire logic          progReady,
   // ----------------------------------------------------------------
   // data read port
   // ----------------------------------------------------------------
   output logic      [AW-1:0] dataRdAddr,
   output logic               dataRdEn,
   input  wire logic [DW-1:0] dataRdata,
   input  wire logic          dataRdReady,
   // ----------------------------------------------------------------
   // data write port
   // ----------------------------------------------------------------
   output logic      [AW-1:0] dataWrAddr,
   output logic               dataWrEn,
   output logic      [DW-1:0] dataWrData,
   input  wire logic          dataWrReady,
   // ----------------------------------------------------------------
   // datapath inputs
   // ----------------------------------------------------------------
   input  wire logic [DW-1:0] storeData,
   input  wire logic          condTrue,
   input  wire logic [AW-1:0] stackTop,
   // ----------------------------------------------------------------
   // execute phase view
   // ----------------------------------------------------------------
   output logic               execValid,
   output logic      [DW-1:0] execWord,
   output logic      [DW-1:0] execOperand,
   output logic      [DW-1:0] execImm,
   output logic      [AW-1:0] execPc,
   output logic               mpyOperandLoad,
   // ----------------------------------------------------------------
   // flow change strobes
   // ----------------------------------------------------------------
   output logic               callPush,
   output logic      [AW-1:0] callReturnAddr,
   output logic               retPop,
   output logic               pipeFlush
);

   // ----------------------------------------------------------------
   // decode helpers
   // ----------------------------------------------------------------
   function automatic logic [2:0] flowOf(input logic [DW-1:0] word);
      flowOf = word[FSDP_F_FLOW_HI:FSDP_F_FLOW_LO];
   endfunction

   function automatic logic isTwoWord(input logic [DW-1:0] word);
      isTwoWord = word[FSDP_F_TWOWORD];
   endfunction

   function automatic logic isMappedStore(input logic [DW-1:0] word);
      isMappedStore = word[FSDP_F_STMAPPED];
   endfunction

   // only indirect operands reach memory; mapped stores never read
   function automatic logic readsOperand(input logic [DW-1:0] word);
      readsOperand = word[FSDP_F_OPERAND] & word[FSDP_F_INDIRECT] & ~word[FSDP_F_STMAPPED];
   endfunction

   function automatic logic writesMemory(input logic [DW-1:0] word);
      writesMemory = word[FSDP_F_WRMEM];
   endfunction

   function automatic logic loadsMpyOperand(input logic [DW-1:0] word);
      loadsMpyOperand = word[FSDP_F_STMPY];
   endfunction

   function automatic logic isReturn(input logic [2:0] flow);
      isReturn = (flow == FSDP_FLOW_RETURN);
   endfunction

   function automatic logic isUncondFlow(input logic [2:0] flow);
      isUncondFlow = (flow == FSDP_FLOW_BRANCH) | (flow == FSDP_FLOW_CALL) | isReturn(flow);
   endfunction

   function automatic logic flowTaken(input logic [2:0] flow,
                                      input logic       cond);
      flowTaken = isUncondFlow(flow) | ((flow == FSDP_FLOW_COND) & cond);
   endfunction

   // return takes the stack top, every other flow the second word
   function automatic logic [AW-1:0] flowTarget(input logic [2:0]    flow,
                                                input logic [AW-1:0] imm,
                                                input logic [AW-1:0] top);
      flowTarget = isReturn(flow) ? top : imm;
   endfunction

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed
   {
      // fetch side
      logic [AW-1:0] pc;
      fsdp_fetch_t   fetchMode;
      logic          progRead;
      // decode slot
      logic          dValid;
      logic          dSecond;
      logic [DW-1:0] dWord;
      logic [AW-1:0] dPc;
      // read slot
      logic          rValid;
      logic [DW-1:0] rWord;
      logic [AW-1:0] rPc;
      logic [AW-1:0] rAddr;
      logic          rdEn;
      // execute slot
      logic          eValid;
      logic [DW-1:0] eWord;
      logic [DW-1:0] eOperand;
      logic [DW-1:0] eImm;
      logic [AW-1:0] ePc;
      logic          mpyLoad;
      // write port
      logic          wrEn;
      logic [AW-1:0] wrAddr;
      logic [DW-1:0] wrData;
      // flow strobes
      logic          flushPulse;
      logic          callPush;
      logic [AW-1:0] retAddr;
      logic          retPop;
   } fsdp_state_t;

   fsdp_state_t st_reg;
   fsdp_state_t st_next;

   // ----------------------------------------------------------------
   // resolved every cycle
   // ----------------------------------------------------------------
   logic          stall;
   logic          dLive;
   logic          taken;
   logic          arUpdate;
   logic [2:0]    eFlow;
   logic [AW-1:0] curAr;

   // ----------------------------------------------------------------
   // aux register unit
   // ----------------------------------------------------------------
   fsdp_aux_unit #(
      .NUM_AR (FSDP_NAR),
      .AW     (AW)
   ) u_aux (
      .clock       (clock),
      .rstn        (rstn),
      .update      (arUpdate),
      .arMod       (st_reg.dWord[FSDP_F_ARMOD_HI:FSDP_F_ARMOD_LO]),
      .newArpValid (st_reg.dWord[FSDP_F_NEWARP_V]),
      .newArp      (st_reg.dWord[FSDP_F_NEWARP_HI:FSDP_F_NEWARP_LO]),
      .curAr       (curAr),
      .curArp      ()
   );

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb
   begin
      st_next            = st_reg;
      st_next.flushPulse = 1'b0;
      st_next.callPush   = 1'b0;
      st_next.retPop     = 1'b0;

      // ----------------------------------------------------------------
      // stall and flow resolve
      // ----------------------------------------------------------------
      // any outstanding wait freezes every phase together
      stall = (st_reg.progRead & ~progReady)
            | (st_reg.rdEn & ~dataRdReady)
            | (st_reg.wrEn & ~dataWrReady);

      eFlow = flowOf(st_reg.eWord);
      // condition result only counts for the conditional flow code
      taken = st_reg.eValid & flowTaken(eFlow, condTrue);

      // second word is only a dummy in decode
      dLive    = st_reg.dValid & ~st_reg.dSecond;
      // decode is dummied in the cycle a branch resolves taken
      arUpdate = ~stall & dLive & ~taken & ~isMappedStore(st_reg.dWord);

      if (!stall)
      begin
         // ----------------------------------------------------------------
         // fetch phase
         // ----------------------------------------------------------------
         st_next.progRead = 1'b1;
         st_next.dValid   = st_reg.progRead;
         st_next.dWord    = progData;
         st_next.dPc      = st_reg.pc;
         st_next.dSecond  = (st_reg.fetchMode == FSDP_FETCH_SECOND);
         if (st_reg.progRead && st_reg.fetchMode == FSDP_FETCH_OPCODE && isTwoWord(progData))
         begin
            st_next.fetchMode = FSDP_FETCH_SECOND;
         end
         else
         begin
            st_next.fetchMode = FSDP_FETCH_OPCODE;
         end
         if (st_reg.progRead)
         begin
            st_next.pc = st_reg.pc + FSDP_PC_STEP;
         end

         // ----------------------------------------------------------------
         // decode phase
         // ----------------------------------------------------------------
         // every phase moves each unstalled cycle, no interlock
         st_next.rValid = dLive;
         st_next.rWord  = st_reg.dWord;
         st_next.rPc    = st_reg.dPc;
         st_next.rAddr  = isMappedStore(st_reg.dWord) ? '0 : curAr;
         st_next.rdEn   = dLive & readsOperand(st_reg.dWord);

         // ----------------------------------------------------------------
         // read phase into execute
         // ----------------------------------------------------------------
         // the dummy slot supplies the second word
         st_next.eValid   = st_reg.rValid;
         st_next.eWord    = st_reg.rWord;
         st_next.ePc      = st_reg.rPc;
         st_next.eOperand = st_reg.rdEn ? dataRdata : '0;
         st_next.eImm     = (st_reg.dValid && st_reg.dSecond) ? st_reg.dWord : '0;
         st_next.mpyLoad  = st_reg.rValid & loadsMpyOperand(st_reg.rWord);
         // write port shares no arbitration with the read port
         st_next.wrEn     = st_reg.rValid & writesMemory(st_reg.rWord);
         st_next.wrAddr   = st_reg.rAddr;
         st_next.wrData   = storeData;

         // ----------------------------------------------------------------
         // execute phase flow change
         // ----------------------------------------------------------------
         // later slots become dummies
         if (taken)
         begin
            st_next.pc         = flowTarget(eFlow, st_reg.eImm, stackTop);
            st_next.fetchMode  = FSDP_FETCH_OPCODE;
            st_next.dValid     = 1'b0;
            st_next.rValid     = 1'b0;
            st_next.rdEn       = 1'b0;
            st_next.eValid     = 1'b0;
            st_next.mpyLoad    = 1'b0;
            st_next.wrEn       = 1'b0;
            st_next.flushPulse = 1'b1;
            st_next.callPush   = (eFlow == FSDP_FLOW_CALL);
            st_next.retAddr    = st_reg.ePc + FSDP_CALL_LEN;
            st_next.retPop     = isReturn(eFlow);
         end
      end
   end

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         st_reg           <= '0;
         st_reg.pc        <= FSDP_PC_RESET;
         st_reg.fetchMode <= FSDP_FETCH_OPCODE;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   // aux, mapped and config hazards are visible by design
   // ----------------------------------------------------------------
   // program port
   // ----------------------------------------------------------------
   assign progAddr       = st_reg.pc;
   assign progRead       = st_reg.progRead;

   // ----------------------------------------------------------------
   // data ports
   // ----------------------------------------------------------------
   assign dataRdAddr     = st_reg.rAddr;
   assign dataRdEn       = st_reg.rdEn;
   assign dataWrAddr     = st_reg.wrAddr;
   assign dataWrEn       = st_reg.wrEn;
   assign dataWrData     = st_reg.wrData;

   // ----------------------------------------------------------------
   // execute view
   // ----------------------------------------------------------------
   assign execValid      = st_reg.eValid;
   assign execWord       = st_reg.eWord;
   assign execOperand    = st_reg.eOperand;
   assign execImm        = st_reg.eImm;
   assign execPc         = st_reg.ePc;
   assign mpyOperandLoad = st_reg.mpyLoad;

   // ----------------------------------------------------------------
   // flow strobes
   // ----------------------------------------------------------------
   assign callPush       = st_reg.callPush;
   assign callReturnAddr = st_reg.retAddr;
   assign retPop         = st_reg.retPop;
   assign pipeFlush      = st_reg.flushPulse;

endmodule

// ### verilog/fsdp_pkg.sv
// Purpose: shared constants for the four stage dsp pipeline control
// Assumes: 16-bit instruction and data words, eight aux registers
// Notes:   instruction field layout below is the control-word encoding seen by this block

package fsdp_pkg;

   // ----------------------------------------------------------------
   // widths and reset values
   // ----------------------------------------------------------------
   localparam int FSDP_DW   = 16;
   localparam int FSDP_AW   = 16;
   localparam int FSDP_NAR  = 8;
   localparam int FSDP_ARPW = 3;

   localparam logic [FSDP_AW-1:0]   FSDP_PC_RESET  = 16'h0000;
   localparam logic [FSDP_AW-1:0]   FSDP_AR_RESET  = 16'h0000;
   localparam logic [FSDP_ARPW-1:0] FSDP_ARP_RESET = 3'h0;

   // ----------------------------------------------------------------
   // instruction control fields
   // ----------------------------------------------------------------
   localparam int FSDP_F_INDIRECT  = 15;
   localparam int FSDP_F_OPERAND   = 14;
   localparam int FSDP_F_TWOWORD   = 13;
   localparam int FSDP_F_ARMOD_HI  = 12;
   localparam int FSDP_F_ARMOD_LO  = 11;
   localparam int FSDP_F_NEWARP_V  = 10;
   localparam int FSDP_F_NEWARP_HI = 9;
   localparam int FSDP_F_NEWARP_LO = 7;
   localparam int FSDP_F_FLOW_HI   = 6;
   localparam int FSDP_F_FLOW_LO   = 4;
   localparam int FSDP_F_STMAPPED  = 3;
   localparam int FSDP_F_STMPY     = 2;
   localparam int FSDP_F_WRMEM     = 1;

   localparam logic [1:0] FSDP_ARMOD_NONE = 2'h0;
   localparam logic [1:0] FSDP_ARMOD_INC  = 2'h1;
   localparam logic [1:0] FSDP_ARMOD_DEC  = 2'h2;

   localparam logic [2:0] FSDP_FLOW_NONE   = 3'h0;
   localparam logic [2:0] FSDP_FLOW_BRANCH = 3'h1;
   localparam logic [2:0] FSDP_FLOW_CALL   = 3'h2;
   localparam logic [2:0] FSDP_FLOW_RETURN = 3'h3;
   localparam logic [2:0] FSDP_FLOW_COND   = 3'h4;

   // call return point skips opcode and target words
   localparam logic [FSDP_AW-1:0] FSDP_CALL_LEN = 16'h0002;
   localparam logic [FSDP_AW-1:0] FSDP_PC_STEP  = 16'h0001;

   // ----------------------------------------------------------------
   // fetch tracking
   // ----------------------------------------------------------------
   typedef enum logic [1:0]
   {
      FSDP_FETCH_OPCODE = 2'b01,
      FSDP_FETCH_SECOND = 2'b10
   } fsdp_fetch_t;

endpackage
